// *** include/ofdc_defs.svh ***
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, byte addresses, one aligned word per register
// Notes:   included by bare name from the design and the bench
`ifndef OFDC_DEFS_SVH
`define OFDC_DEFS_SVH

// register byte addresses
`define OFDC_A_OUT_FORCE   8'h00
`define OFDC_A_GRP_FORCE   8'h04
`define OFDC_A_DISARM      8'h08
`define OFDC_A_OUT_TMR     8'h0c
`define OFDC_A_DIS_TMR     8'h10
`define OFDC_A_ANA_CTRL    8'h14
`define OFDC_A_ANA_TMR     8'h18
`define OFDC_A_FV0         8'h1c
`define OFDC_A_DISP0       8'h28
`define OFDC_A_STATUS      8'h34
`define OFDC_A_IRQ_ST      8'h38
`define OFDC_A_IRQ_MASK    8'h3c
`define OFDC_A_CFG         8'h40

// field positions
`define OFDC_F_SGL_VAL     8
`define OFDC_F_GRP_VAL     8
`define OFDC_F_TIMED       16
`define OFDC_F_DIS_CTRL    8
`define OFDC_F_ANA_TIMED   4
`define OFDC_F_ST_DIS      8
`define OFDC_F_ST_OUT      16
`define OFDC_F_ST_HEALTH   24
`define OFDC_F_ST_PHASE    25

// reset values
`define OFDC_RST_TMR       16'h0000
`define OFDC_RST_VAL       16'h0000

// timing: timers count in milliseconds
`define OFDC_CLK_MHZ       100
`define OFDC_TICK_US       1000
`define OFDC_TICK_CYC      (`OFDC_TICK_US * `OFDC_CLK_MHZ)

`endif

// *** include/ofdc_pkg.sv ***
// Purpose: shared types of the output force and disarm control
// Assumes: constants live in ofdc_defs.svh
// Notes:   timer indices select one of the three countdown timers
package ofdc_pkg;
    typedef logic [15:0] ofdc_val_t;
    typedef logic [15:0] ofdc_ms_t;
    typedef enum logic [1:0] {
        OFDC_TMR_FORCE  = 2'b00,
        OFDC_TMR_DISARM = 2'b01,
        OFDC_TMR_ANALOG = 2'b10
    } ofdc_tmr_t;
endpackage

// *** src/ofdc_top.sv ***
// Purpose: service override of relay contacts and analog channels
// Assumes: protection logic, measurements and strap levels on hclk
// Notes:   ahb-lite slave, zero wait states, always okay
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ofdc_defs.svh"

module ofdc_top
    import ofdc_pkg::*;
#(
    parameter int NGRP     = 2,
    parameter int NPER     = 4,
    parameter int TICK_CYC = `OFDC_TICK_CYC
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [NGRP*NPER-1:0] prot_out,
    input  wire logic [NGRP*NPER-1:0] contact_latched,
    input  wire logic [NGRP*NPER-1:0] hold_timer_run,
    output logic      [NGRP*NPER-1:0] contact_out,
    input  wire logic                 prot_zone_out,
    input  wire logic                 prot_superv_out,
    output logic                      zone_out,
    output logic                      superv_out,
    input  wire ofdc_pkg::ofdc_val_t  rtd_meas,
    input  wire ofdc_pkg::ofdc_val_t  ao_assigned,
    input  wire ofdc_pkg::ofdc_val_t  ai_meas,
    output ofdc_pkg::ofdc_val_t       rtd_value,
    output ofdc_pkg::ofdc_val_t       ao_value,
    output ofdc_pkg::ofdc_val_t       ai_value,
    input  wire logic                 boot_done,
    input  wire logic                 prot_running,
    output logic                      healthy_green,
    input  wire logic                 phase_rot_calc,
    output logic                      phase_mismatch,
    output logic                      irq
);
    import ofdc_pkg::*;

    localparam int NOUT = NGRP * NPER;
    localparam int NANA = 3;
    localparam int TW   = $clog2(TICK_CYC + 1);

    // bus capture
    logic              wr_q;
    logic [7:0]        wa_q;
    logic [31:0]       rd_d;
    logic              rd_q;
    logic              acc;
    logic [7:0]        aa;

    // software state
    logic [NOUT-1:0]   sgl_en_q;
    logic [NOUT-1:0]   sgl_val_q;
    logic [NGRP-1:0]   grp_en_q;
    logic [NGRP-1:0]   grp_val_q;
    logic              out_timed_q;
    logic [NGRP-1:0]   dis_cmd_q;
    logic              dis_ctrl_q;
    logic              dis_timed_q;
    ofdc_ms_t          tmr_load_q [3];
    logic [NANA-1:0]   ana_en_q;
    logic [NANA-1:0]   ana_timed_q;
    ofdc_val_t         fv_q       [NANA];
    logic              phase_set_q;
    logic [3:0]        irq_st_q;
    logic [3:0]        irq_mask_q;

    // block state
    logic [TW-1:0]     div_q;
    logic              tick;
    ofdc_ms_t          tmr_q      [3];
    logic [2:0]        tmr_start;
    logic [2:0]        tmr_exp;
    logic [NOUT-1:0]   disarmed_q;
    logic [NOUT-1:0]   out_q;
    logic [NOUT-1:0]   fon_v;
    ofdc_val_t         live       [NANA];
    ofdc_val_t         val_q      [NANA];
    ofdc_val_t         disp_q     [NANA];
    logic              mis_q;
    logic              green_q;
    logic [3:0]        ev;

    assign acc = hsel & htrans[1] & hready;
    assign aa  = haddr[7:0];

    // address phase latched; data phase completes in the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            rd_q <= 1'b0;
        end else begin
            wr_q <= acc & hwrite;
            wa_q <= aa;
            rd_q <= acc & ~hwrite;
        end
    end

    // read data from flops, captured in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (aa)
            `OFDC_A_OUT_FORCE: begin
                rd_d[NOUT-1:0] = sgl_en_q;
                rd_d[`OFDC_F_SGL_VAL +: NOUT] = sgl_val_q;
                rd_d[`OFDC_F_TIMED] = out_timed_q;
            end
            `OFDC_A_GRP_FORCE: begin
                rd_d[NGRP-1:0] = grp_en_q;
                rd_d[`OFDC_F_GRP_VAL +: NGRP] = grp_val_q;
            end
            `OFDC_A_DISARM: begin
                rd_d[NGRP-1:0] = dis_cmd_q;
                rd_d[`OFDC_F_DIS_CTRL] = dis_ctrl_q;
                rd_d[`OFDC_F_TIMED] = dis_timed_q;
            end
            `OFDC_A_OUT_TMR:  rd_d = {tmr_q[0], tmr_load_q[0]};
            `OFDC_A_DIS_TMR:  rd_d = {tmr_q[1], tmr_load_q[1]};
            `OFDC_A_ANA_TMR:  rd_d = {tmr_q[2], tmr_load_q[2]};
            `OFDC_A_ANA_CTRL: begin
                rd_d[NANA-1:0] = ana_en_q;
                rd_d[`OFDC_F_ANA_TIMED +: NANA] = ana_timed_q;
            end
            `OFDC_A_FV0:       rd_d[15:0] = fv_q[0];
            `OFDC_A_FV0 + 8'h04: rd_d[15:0] = fv_q[1];
            `OFDC_A_FV0 + 8'h08: rd_d[15:0] = fv_q[2];
            `OFDC_A_DISP0:     rd_d[15:0] = disp_q[0];
            `OFDC_A_DISP0 + 8'h04: rd_d[15:0] = disp_q[1];
            `OFDC_A_DISP0 + 8'h08: rd_d[15:0] = disp_q[2];
            `OFDC_A_STATUS: begin
                rd_d[NOUT-1:0] = fon_v; // per contact, a group force marks only its group
                rd_d[`OFDC_F_ST_DIS +: NOUT] = disarmed_q;
                rd_d[`OFDC_F_ST_OUT +: NOUT] = out_q;
                rd_d[`OFDC_F_ST_HEALTH] = green_q;
                rd_d[`OFDC_F_ST_PHASE] = mis_q;
            end
            `OFDC_A_IRQ_ST:   rd_d[3:0] = irq_st_q;
            `OFDC_A_IRQ_MASK: rd_d[3:0] = irq_mask_q;
            `OFDC_A_CFG:      rd_d[0] = phase_set_q;
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    // contact force setup; a write wins over a timer expiry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sgl_en_q    <= '0;
            sgl_val_q   <= '0;
            grp_en_q    <= '0;
            grp_val_q   <= '0;
            out_timed_q <= 1'b0;
        end else if (wr_q && wa_q == `OFDC_A_OUT_FORCE) begin
            sgl_en_q    <= hwdata[NOUT-1:0];
            sgl_val_q   <= hwdata[`OFDC_F_SGL_VAL +: NOUT];
            out_timed_q <= hwdata[`OFDC_F_TIMED];
        end else if (wr_q && wa_q == `OFDC_A_GRP_FORCE) begin
            grp_en_q    <= hwdata[NGRP-1:0];
            grp_val_q   <= hwdata[`OFDC_F_GRP_VAL +: NGRP];
        end else if (tmr_exp[OFDC_TMR_FORCE] && out_timed_q) begin
            sgl_en_q    <= '0;
            grp_en_q    <= '0;
        end
    end

    // disarm setup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dis_cmd_q   <= '0;
            dis_ctrl_q  <= 1'b0;
            dis_timed_q <= 1'b0;
        end else if (wr_q && wa_q == `OFDC_A_DISARM) begin
            dis_cmd_q   <= hwdata[NGRP-1:0];
            dis_ctrl_q  <= hwdata[`OFDC_F_DIS_CTRL];
            dis_timed_q <= hwdata[`OFDC_F_TIMED];
        end else if (tmr_exp[OFDC_TMR_DISARM] && dis_timed_q) begin
            dis_cmd_q   <= '0;
        end
    end

    // analog force setup; expiry clears only the timed channels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ana_en_q    <= '0;
            ana_timed_q <= '0;
        end else if (wr_q && wa_q == `OFDC_A_ANA_CTRL) begin
            ana_en_q    <= hwdata[NANA-1:0];
            ana_timed_q <= hwdata[`OFDC_F_ANA_TIMED +: NANA];
        end else if (tmr_exp[OFDC_TMR_ANALOG]) begin
            ana_en_q    <= ana_en_q & ~ana_timed_q;
        end
    end

    // durations, force values and configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_load_q  <= '{`OFDC_RST_TMR, `OFDC_RST_TMR, `OFDC_RST_TMR};
            fv_q        <= '{`OFDC_RST_VAL, `OFDC_RST_VAL, `OFDC_RST_VAL};
            phase_set_q <= 1'b0;
            irq_mask_q  <= 4'h0;
        end else if (wr_q) begin
            unique case (wa_q)
                `OFDC_A_OUT_TMR:       tmr_load_q[0] <= hwdata[15:0];
                `OFDC_A_DIS_TMR:       tmr_load_q[1] <= hwdata[15:0];
                `OFDC_A_ANA_TMR:       tmr_load_q[2] <= hwdata[15:0];
                `OFDC_A_FV0:           fv_q[0] <= hwdata[15:0];
                `OFDC_A_FV0 + 8'h04:   fv_q[1] <= hwdata[15:0];
                `OFDC_A_FV0 + 8'h08:   fv_q[2] <= hwdata[15:0];
                `OFDC_A_CFG:           phase_set_q <= hwdata[0];
                `OFDC_A_IRQ_MASK:      irq_mask_q <= hwdata[3:0];
                default:               ;
            endcase
        end
    end

    // millisecond enable pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
        end else if (div_q == TW'(TICK_CYC - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = (div_q == TW'(TICK_CYC - 1));

    // timed activation: a write that turns something on with timed mode set
    always_comb begin
        tmr_start[OFDC_TMR_FORCE] = wr_q && hwdata[`OFDC_F_TIMED]
            && ((wa_q == `OFDC_A_OUT_FORCE && hwdata[NOUT-1:0] != '0)
             || (wa_q == `OFDC_A_GRP_FORCE && hwdata[NGRP-1:0] != '0 && out_timed_q));
        tmr_start[OFDC_TMR_DISARM] = wr_q && wa_q == `OFDC_A_DISARM
            && hwdata[`OFDC_F_TIMED] && hwdata[NGRP-1:0] != '0;
        tmr_start[OFDC_TMR_ANALOG] = wr_q && wa_q == `OFDC_A_ANA_CTRL
            && (hwdata[NANA-1:0] & hwdata[`OFDC_F_ANA_TIMED +: NANA]) != '0;
    end

    // countdown timers, one per override kind
    for (genvar k = 0; k < 3; k++) begin : g_tmr
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tmr_q[k] <= `OFDC_RST_TMR;
            end else if (tmr_start[k]) begin
                tmr_q[k] <= tmr_load_q[k];
            end else if (tick && tmr_q[k] != 16'h0000) begin
                tmr_q[k] <= tmr_q[k] - 16'h0001;
            end
        end
        assign tmr_exp[k] = tick && tmr_q[k] == 16'h0001 && !tmr_start[k];
    end

    // per-contact disarm and output drive
    for (genvar i = 0; i < NOUT; i++) begin : g_out
        localparam int G = i / NPER;
        logic dis_req;
        logic fval;
        logic fon;
        // group-wide request, gated by the control bit
        assign dis_req = dis_ctrl_q & dis_cmd_q[G];
        assign fon  = grp_en_q[G] | sgl_en_q[i];
        assign fval = grp_en_q[G] ? grp_val_q[G] : sgl_val_q[i];
        assign fon_v[i] = fon;

        // entering disarm waits for latch reset and hold timer expiry
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                disarmed_q[i] <= 1'b0;
            end else begin
                disarmed_q[i] <= dis_req & (disarmed_q[i] |
                                 (~contact_latched[i] & ~hold_timer_run[i]));
            end
        end

        // a disarmed contact keeps its position: no switching, no forcing
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                out_q[i] <= 1'b0;
            end else if (disarmed_q[i]) begin
                out_q[i] <= out_q[i];
            end else if (fon) begin
                out_q[i] <= fval;
            end else begin
                out_q[i] <= prot_out[i];
            end
        end
    end
    assign contact_out = out_q;

    // never disarmed, never forced: straight pass-through
    assign zone_out   = prot_zone_out;
    assign superv_out = prot_superv_out;

    assign live[0] = rtd_meas;
    assign live[1] = ao_assigned;
    assign live[2] = ai_meas;

    // analog channels: 0 rtd, 1 analog output, 2 analog input
    for (genvar c = 0; c < NANA; c++) begin : g_ana
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                val_q[c] <= `OFDC_RST_VAL;
            end else begin
                val_q[c] <= ana_en_q[c] ? fv_q[c] : live[c];
            end
        end
        // display freezes the last tracked value while forced
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                disp_q[c] <= `OFDC_RST_VAL;
            end else if (!ana_en_q[c]) begin
                disp_q[c] <= live[c];
            end
        end
    end
    assign rtd_value = val_q[0];
    assign ao_value  = val_q[1];
    assign ai_value  = val_q[2];

    // health lamp and phase rotation supervision
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            green_q <= 1'b0;
            mis_q   <= 1'b0;
        end else begin
            green_q <= boot_done & prot_running;
            mis_q   <= phase_rot_calc ^ phase_set_q;
        end
    end
    assign healthy_green  = green_q;
    assign phase_mismatch = mis_q;

    // events: three expiries and the onset of a phase mismatch
    assign ev = {(phase_rot_calc ^ phase_set_q) & ~mis_q, tmr_exp};

    // sticky status; read clears, a new event in the same cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= 4'h0;
        end else if (acc && !hwrite && aa == `OFDC_A_IRQ_ST) begin
            irq_st_q <= ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
    end
    assign irq = |(irq_st_q & irq_mask_q);

endmodule
`default_nettype wire

// *** bench/ofdc_top_properties.sv ***
// Purpose: concurrent checks on the override block ports
// Assumes: single hclk domain, hresetn active low
// Notes:   bound to ofdc_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none

module ofdc_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        prot_zone_out,
    input wire logic        prot_superv_out,
    input wire logic        zone_out,
    input wire logic        superv_out,
    input wire logic        boot_done,
    input wire logic        prot_running,
    input wire logic        healthy_green,
    input wire logic        phase_rot_calc,
    input wire logic        phase_mismatch,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // zero wait state slave, never an error
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    // read data stands until the next read address phase
    chk_rdata_stands: assert property (!(hsel && htrans[1] && hready && !hwrite)
        |=> $stable(hrdata)) else $error("hrdata moved without read");
    // these two bypass disarm and force entirely
    chk_zone_follow: assert property (zone_out == prot_zone_out)
        else $error("zone output altered");
    chk_superv_follow: assert property (superv_out == prot_superv_out)
        else $error("supervision output altered");
    chk_health_on: assert property (boot_done && prot_running |=> healthy_green)
        else $error("healthy not green");
    chk_health_off: assert property (!(boot_done && prot_running) |=> !healthy_green)
        else $error("healthy green too early");
    // bench never moves the setting and the input on one edge
    chk_phase_track: assert property ($changed(phase_rot_calc) |=> $changed(phase_mismatch))
        else $error("phase flag did not follow");

    cov_irq: cover property (irq);
    cov_phase: cover property ($rose(phase_mismatch));
    cov_health: cover property ($rose(healthy_green));
endmodule

bind ofdc_top ofdc_checker u_ofdc_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .prot_zone_out(prot_zone_out), .prot_superv_out(prot_superv_out),
    .zone_out(zone_out), .superv_out(superv_out), .boot_done(boot_done),
    .prot_running(prot_running), .healthy_green(healthy_green),
    .phase_rot_calc(phase_rot_calc), .phase_mismatch(phase_mismatch), .irq(irq)
);
`default_nettype wire

// *** bench/ofdc_field_model.sv ***
// Purpose: field side giving live rtd, analog output and analog input values
// Assumes: values move only when the bench asks, so displays can be compared
// Notes:   each step pulse of one cycle advances every channel by one
`timescale 1ns/1ns
`default_nettype none

module ofdc_field_model (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               step,
    output var ofdc_pkg::ofdc_val_t rtd_meas,
    output var ofdc_pkg::ofdc_val_t ao_assigned,
    output var ofdc_pkg::ofdc_val_t ai_meas
);
    import ofdc_pkg::*;
    logic [7:0] step_q;

    // measurement drift, held still between steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) step_q <= 8'h00;
        else if (step) step_q <= step_q + 8'h01;
    end
    assign rtd_meas    = {8'h01, step_q};
    assign ao_assigned = {8'h02, step_q};
    assign ai_meas     = {8'h03, step_q};
endmodule
`default_nettype wire

// *** bench/tb_output_force_disarm_control.sv ***
// Purpose: directed scenarios for contact force, disarm and analog override
// Assumes: TICK_CYC shortened to 10 so a 1 ms tick is 10 cycles
// Notes:   bus writes take effect one edge after the data phase
`timescale 1ns/1ns
`default_nettype none
`include "ofdc_defs.svh"

module tb_output_force_disarm_control;
    import ofdc_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [7:0]  prot_out = 0, latched = 0, hold_run = 0, contact_out;
    logic        pz = 0, ps = 0, zone_out, superv_out, step = 0, irq;
    logic        boot_done = 0, prot_running = 0, healthy_green, phase_calc = 0, phase_mm;
    ofdc_val_t   rtd_meas, ao_assigned, ai_meas, rtd_value, ao_value, ai_value;
    int          fail_count = 0, samples_checked = 0, cyc = 0;

    assign hready = hreadyout;
    ofdc_top #(.TICK_CYC(10)) u_ofdc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .prot_out(prot_out), .contact_latched(latched), .hold_timer_run(hold_run),
        .contact_out(contact_out), .prot_zone_out(pz), .prot_superv_out(ps),
        .zone_out(zone_out), .superv_out(superv_out), .rtd_meas(rtd_meas),
        .ao_assigned(ao_assigned), .ai_meas(ai_meas), .rtd_value(rtd_value),
        .ao_value(ao_value), .ai_value(ai_value), .boot_done(boot_done),
        .prot_running(prot_running), .healthy_green(healthy_green),
        .phase_rot_calc(phase_calc), .phase_mismatch(phase_mm), .irq(irq));
    ofdc_field_model u_ofdc_field_model (.hclk(hclk), .hresetn(hresetn), .step(step),
        .rtd_meas(rtd_meas), .ao_assigned(ao_assigned), .ai_meas(ai_meas));

    initial begin
        forever #5 hclk = ~hclk;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // address phase held until hready, then data phase until hready
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task t_reset;
        bus(`OFDC_A_STATUS, 0, 0);
        chk(rd, 32'h0);
        bus(8'h80, 1, 32'hffff_ffff);
        bus(8'h80, 0, 0);
        chk(rd, 32'h0);
        chk(32'(contact_out), 32'h0);
        bus(`OFDC_A_IRQ_MASK, 0, 0);
        chk(rd, 32'h0);
        $display("done reset");
    endtask
    task t_force_perm;
        @(posedge hclk) prot_out <= 8'h3c;
        bus(`OFDC_A_OUT_FORCE, 1, 32'h0000_050f);
        wt(2);
        chk(32'(contact_out), 32'h35);
        wt(60);
        chk(32'(contact_out), 32'h35);
        bus(`OFDC_A_GRP_FORCE, 1, 32'h0000_0201);
        wt(2);
        chk(32'(contact_out), 32'h30);
        bus(`OFDC_A_GRP_FORCE, 1, 32'h0000_0203);
        wt(2);
        chk(32'(contact_out), 32'hf0);
        bus(`OFDC_A_GRP_FORCE, 1, 0);
        bus(`OFDC_A_OUT_FORCE, 1, 0);
        wt(2);
        chk(32'(contact_out), 32'h3c);
        $display("done force_perm");
    endtask
    task t_force_timed;
        @(posedge hclk) prot_out <= 8'h00;
        bus(`OFDC_A_IRQ_MASK, 1, 32'hf);
        bus(`OFDC_A_OUT_TMR, 1, 32'h3);
        bus(`OFDC_A_OUT_FORCE, 1, 32'h0001_0a0f);
        wt(2);
        chk(32'(contact_out), 32'h0a);
        wt(50);
        chk(32'(contact_out), 32'h00);
        chk(32'(irq), 32'h1);
        bus(`OFDC_A_IRQ_ST, 0, 0);
        chk(rd & 32'h1, 32'h1);
        wt(2);
        chk(32'(irq), 32'h0);
        $display("done force_timed");
    endtask
    task t_disarm;
        @(posedge hclk);
        prot_out <= 8'hff;
        latched <= 8'h10;
        hold_run <= 8'h01;
        bus(`OFDC_A_IRQ_MASK, 1, 0);
        bus(`OFDC_A_DISARM, 1, 32'h3);
        bus(`OFDC_A_STATUS, 0, 0);
        chk((rd >> 8) & 32'hff, 32'h00);
        bus(`OFDC_A_DISARM, 1, 32'h103);
        bus(`OFDC_A_STATUS, 0, 0);
        chk((rd >> 8) & 32'hff, 32'hee);
        @(posedge hclk);
        prot_out <= 8'h00;
        pz <= 1;
        ps <= 1;
        wt(2);
        chk(32'(contact_out), 32'hee);
        chk(32'(zone_out), 32'h1);
        chk(32'(superv_out), 32'h1);
        bus(`OFDC_A_OUT_FORCE, 1, 32'h0000_00ee);
        wt(2);
        chk(32'(contact_out), 32'hee);
        bus(`OFDC_A_OUT_FORCE, 1, 0);
        bus(`OFDC_A_DIS_TMR, 1, 32'h2);
        bus(`OFDC_A_DISARM, 1, 32'h1_0103);
        wt(40);
        chk(32'(contact_out), 32'h00);
        chk(32'(irq), 32'h0);
        bus(`OFDC_A_IRQ_ST, 0, 0);
        chk(rd & 32'h2, 32'h2);
        $display("done disarm");
    endtask
    task t_analog;
        bus(`OFDC_A_FV0, 1, 32'h1111);
        bus(`OFDC_A_FV0 + 8'h04, 1, 32'h2222);
        bus(`OFDC_A_FV0 + 8'h08, 1, 32'h3333);
        bus(`OFDC_A_ANA_TMR, 1, 32'h2);
        bus(`OFDC_A_DISP0, 0, 0);
        chk(rd, 32'h0100);
        bus(`OFDC_A_ANA_CTRL, 1, 32'h27);
        wt(2);
        chk({rtd_value, ai_value}, 32'h1111_3333);
        chk(32'(ao_value), 32'h2222);
        @(posedge hclk) step <= 1;
        @(posedge hclk) step <= 0;
        bus(`OFDC_A_DISP0, 0, 0);
        chk(rd, 32'h0100);
        bus(`OFDC_A_DISP0 + 8'h04, 0, 0);
        chk(rd, 32'h0200);
        bus(`OFDC_A_DISP0 + 8'h08, 0, 0);
        chk(rd, 32'h0300);
        wt(40);
        chk(32'(ao_value), 32'h0201);
        chk(32'(rtd_value), 32'h1111);
        bus(`OFDC_A_ANA_CTRL, 1, 0);
        wt(2);
        chk({rtd_value, ai_value}, 32'h0101_0301);
        bus(`OFDC_A_DISP0, 0, 0);
        chk(rd, 32'h0101);
        bus(`OFDC_A_DISP0 + 8'h04, 0, 0);
        chk(rd, 32'h0201);
        bus(`OFDC_A_DISP0 + 8'h08, 0, 0);
        chk(rd, 32'h0301);
        $display("done analog");
    endtask
    task t_health;
        @(posedge hclk) boot_done <= 1;
        wt(2);
        chk(32'(healthy_green), 32'h0);
        @(posedge hclk) prot_running <= 1;
        wt(2);
        chk(32'(healthy_green), 32'h1);
        @(posedge hclk) phase_calc <= 1;
        wt(2);
        chk(32'(phase_mm), 32'h1);
        bus(`OFDC_A_CFG, 1, 32'h1);
        wt(2);
        chk(32'(phase_mm), 32'h0);
        bus(`OFDC_A_STATUS, 0, 0);
        chk(rd >> 24, 32'h1);
        bus(`OFDC_A_IRQ_ST, 0, 0);
        chk(rd & 32'h8, 32'h8);
        $display("done health");
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        t_reset();
        t_force_perm();
        t_force_timed();
        t_disarm();
        t_analog();
        t_health();
        tally_and_finish();
    end
endmodule
`default_nettype wire
